/* File: sim/kpsc_dev_model.sv */
/*
 Behavioural keyboard or pointer device on one clocked serial port.
 Assumes an open-drain clock wire with a pull-up, resolved by the bench.
*/
`default_nettype none
module kpsc_dev_model (
   input wire logic lineClk,
   output logic clkDrv,
   output logic dataDrv
);
   timeunit 1ns;
   timeprecision 1ns;
   // Both lines are released, so the pull-ups hold them high.
   initial begin
      clkDrv = 1'b1;
      dataDrv = 1'b1;
   end
   // Sends start, eight bits LSB first, parity and stop at 400 ns a bit.
   // A clock held low by the system means it may not send, so it waits.
   task automatic sendByte(input logic [7:0] b, input logic badPar);
      logic [10:0] f;
      int i;
      f = {1'b1, (~^b) ^ badPar, b, 1'b0};
      for (i = 0; i < 1000 && lineClk !== 1'b1; i++) begin
         #100;
      end
      for (i = 0; i < 11; i++) begin
         dataDrv = f[i];
         #100 clkDrv = 1'b0;
         #200 clkDrv = 1'b1;
         #100;
      end
      dataDrv = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: sim/test_kbd_pointer_port_ctrl_status.sv */
/*
 Self-checking bench for the port control and status register bank.
 Assumes kpsc_top on a 20 MHz clock and two device models on the ports.
*/
`default_nettype none
module test_kbd_pointer_port_ctrl_status;
   timeunit 1ns;
   timeprecision 1ns;
   import kpsc_pkg::*;
   logic mclk, rst_n, cyc, stb, we, ack, keyUnl, densN, rtcIrq, rtcRd;
   logic clkOe1, clkOe2, irq, diagEn, diagRb, nmiEn, m1Clk, m2Clk;
   logic m1Dat, m2Dat, bad, viaTx, clkOut1, clkOut2;
   logic [ADDR_W-1:0] adr;
   logic [31:0] wdat, rdat;
   logic [8:0] tx1, tx2;
   logic [7:0] seed, q, ex, ep;
   int fails, n_compared, k, p;
   // Open-drain clock wires: pulled up, low while either side drives.
   wire logic line1 = m1Clk & (clkOut1 | ~clkOe1);
   wire logic line2 = m2Clk & (clkOut2 | ~clkOe2);
   kpsc_top dut (.mclk(mclk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
      .ack_o(ack), .firstPortClkIn(line1), .firstPortClkOut(clkOut1),
      .firstPortClkOe(clkOe1), .firstPortDataIn(m1Dat),
      .secondPortClkIn(line2), .secondPortClkOut(clkOut2),
      .secondPortClkOe(clkOe2), .secondPortDataIn(m2Dat),
      .firstPortTxFrame(tx1), .secondPortTxFrame(tx2),
      .keyUnlockedIn(keyUnl), .floppyDensityIn_n(densN), .rtcIrq(rtcIrq),
      .rtcStatusRead(rtcRd), .sharedInterruptRequest(irq),
      .diagEnable(diagEn), .diagReadBlock(diagRb), .nmiDiagEnable(nmiEn));
   kpsc_dev_model m1 (.lineClk(line1), .clkDrv(m1Clk), .dataDrv(m1Dat));
   kpsc_dev_model m2 (.lineClk(line2), .clkDrv(m2Clk), .dataDrv(m2Dat));
   // The 50 ns clock.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Repeatable random source.
   function automatic logic [7:0] lfsrNext(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input string name, input logic [8:0] e,
                      input logic [8:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask
   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
      int n;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      for (n = 0; n < 20 && ack !== 1'b1; n++) begin
         @(posedge mclk);
      end
      if (ack !== 1'b1) begin
         fails++;
         wrap_up();
      end
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic chkRd(input logic [9:0] idx, input logic [7:0] e,
                        input string name);
      wb(1'b0, idx, 8'h00);
      cmp(name, {1'b0, e}, {1'b0, q});
   endtask
   task automatic settle();
      repeat (2) @(negedge mclk);
   endtask
   // Main sequence.
   initial begin
      {rst_n, cyc, stb, we, rtcIrq, rtcRd, densN} = '0;
      adr = '0;
      wdat = '0;
      keyUnl = 1'b1;
      seed = 8'h4f;
      fails = 0;
      n_compared = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(negedge mclk);
      cmp("clkOe1", 9'h1, {8'h0, clkOe1});
      cmp("clkOe2", 9'h1, {8'h0, clkOe2});
      chkRd(IDX_RXCTL, 8'h04, "rxctl");
      chkRd(IDX_TXCTL, 8'h00, "txctl");
      chkRd(IDX_IRQMASK, 8'h00, "mask");
      chkRd(IDX_IRQSTAT, 8'h00, "irqstat");
      chkRd(IDX_RXSTAT, 8'h48, "rxstat");
      chkRd(10'h000, 8'h00, "unmapped");
      wb(1'b1, IDX_RXCTL, 8'ha8);
      settle();
      cmp("clkOe1", 9'h0, {8'h0, clkOe1});
      cmp("clkOe2", 9'h0, {8'h0, clkOe2});
      // Switch inputs drawn at random reach their status bits.
      for (k = 0; k < 4; k++) begin
         seed = lfsrNext(seed);
         @(posedge mclk);
         keyUnl <= seed[0];
         densN <= seed[1];
         repeat (4) @(posedge mclk);
         chkRd(IDX_RXCTL, {5'h15, seed[0], 2'b00}, "rxctl");
         chkRd(IDX_RXSTAT, {7'h24, seed[1]}, "rxstat");
      end
      wb(1'b1, IDX_TXCTL, 8'hc4);
      settle();
      cmp("diag", 9'h7, {6'h0, diagEn, diagRb, nmiEn});
      chkRd(IDX_TXCTL, 8'hc4, "txctl");
      wb(1'b1, IDX_TXCTL, 8'h20);
      settle();
      cmp("clkOeBoth", 9'h3, {7'h0, clkOe1, clkOe2});
      wb(1'b1, IDX_TXCTL, 8'h00);
      // Receive on each port, good and bad parity, both clear paths.
      for (k = 0; k < 4; k++) begin
         p = k & 1;
         bad = k[1];
         viaTx = k[0] ^ k[1];
         seed = lfsrNext(seed);
         ex = p ? 8'h08 : 8'h40;
         fork
            if (p == 0) m1.sendByte(seed, bad);
            else m2.sendByte(seed, bad);
            begin
               #1200;
               chkRd(IDX_RXSTAT, ex | densN, "busy");
            end
         join
         repeat (10) @(negedge mclk);
         ex = 8'h48 | densN | (p ? 8'h04 : 8'h20);
         ep = {5'h15, keyUnl, bad & p[0], bad & ~p[0]};
         chkRd(IDX_RXSTAT, ex, "rxstat");
         chkRd(IDX_IRQSTAT, p ? 8'h08 : 8'h04, "irqstat");
         cmp("irq", 9'h1, {8'h0, irq});
         cmp("hold", 9'h1, {8'h0, p ? clkOe2 : clkOe1});
         chkRd(p ? IDX_TXDATA2 : IDX_TXDATA1, seed, "rxbyte");
         chkRd(IDX_RXCTL, ep, "perr");
         wb(1'b1, IDX_IRQMASK, p ? 8'h08 : 8'h04);
         settle();
         cmp("irqMasked", 9'h0, {8'h0, irq});
         chkRd(IDX_RXSTAT, ex, "rxstatMasked");
         chkRd(IDX_IRQSTAT, p ? 8'h08 : 8'h04, "irqMasked");
         wb(1'b1, IDX_IRQMASK, 8'h00);
         if (viaTx) begin
            wb(1'b1, IDX_TXCTL, p ? 8'h10 : 8'h08);
            wb(1'b1, IDX_TXCTL, 8'h00);
         end else begin
            wb(1'b1, IDX_RXCTL, p ? 8'he8 : 8'hb8);
            wb(1'b1, IDX_RXCTL, 8'ha8);
         end
         settle();
         ep = {5'h15, keyUnl, 2'b00};
         chkRd(IDX_RXSTAT, 8'h48 | densN, "rxstatClr");
         chkRd(IDX_IRQSTAT, 8'h00, "irqClr");
         chkRd(IDX_RXCTL, ep, "perrClr");
         cmp("irqClr", 9'h0, {8'h0, irq});
         cmp("holdClr", 9'h0, {8'h0, p ? clkOe2 : clkOe1});
      end
      // Clock source: pending, masked, cleared only by its status read.
      @(posedge mclk);
      rtcIrq <= 1'b1;
      @(posedge mclk);
      rtcIrq <= 1'b0;
      settle();
      cmp("irqRtc", 9'h1, {8'h0, irq});
      wb(1'b1, IDX_IRQMASK, 8'h01);
      settle();
      cmp("irqRtcMasked", 9'h0, {8'h0, irq});
      chkRd(IDX_IRQSTAT, 8'h01, "irqRtc");
      @(posedge mclk);
      rtcRd <= 1'b1;
      @(posedge mclk);
      rtcRd <= 1'b0;
      settle();
      chkRd(IDX_IRQSTAT, 8'h00, "irqRtcClr");
      wb(1'b1, IDX_IRQMASK, 8'h00);
      // Transmit bytes are stored with odd parity and start nothing.
      seed = lfsrNext(seed);
      wb(1'b1, IDX_TXDATA1, seed);
      wb(1'b1, IDX_TXDATA2, ~seed);
      settle();
      cmp("tx1", {~^seed, seed}, tx1);
      cmp("tx2", {~^seed, ~seed}, tx2);
      cmp("txIdle", 9'h0, {7'h0, clkOe1, clkOe2});
      // Toggle held high and port masked: no hold, no request, yet the
      // status bits still report the byte.
      wb(1'b1, IDX_RXCTL, 8'hb8);
      wb(1'b1, IDX_IRQMASK, 8'h04);
      m1.sendByte(seed, 1'b0);
      repeat (10) @(negedge mclk);
      cmp("noHold", 9'h0, {8'h0, clkOe1});
      cmp("irqMaskedRx", 9'h0, {8'h0, irq});
      chkRd(IDX_IRQSTAT, 8'h04, "irqMaskedRx");
      chkRd(IDX_RXSTAT, 8'h68 | densN, "rxstatMaskedRx");
      chkRd(IDX_TXDATA1, seed, "rxbyteMasked");
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: verilog/kpsc_pkg.sv */
/*
 Constants and carrier types for the keyboard and pointer port
 control and status block.
 Assumes a word-addressed classic Wishbone slave at 32 bits.
*/
`default_nettype none
package kpsc_pkg;
   // ----------------------------------------------------------
   // Register indices; the byte address is four times these.
   // ----------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_RXCTL = 10'h066;
   localparam logic [9:0] IDX_TXDATA1 = 10'h067;
   localparam logic [9:0] IDX_TXDATA2 = 10'h068;
   localparam logic [9:0] IDX_TXCTL = 10'h069;
   localparam logic [9:0] IDX_RXSTAT = 10'h06a;
   localparam logic [9:0] IDX_IRQSTAT = 10'h0a0;
   localparam logic [9:0] IDX_IRQMASK = 10'h0a1;
   // ----------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------
   localparam int RC_DRV2 = 7;
   localparam int RC_TOG2 = 6;
   localparam int RC_DRV1 = 5;
   localparam int RC_TOG1 = 4;
   localparam int RC_KBD1 = 3;
   localparam int RC_LOCK = 2;
   localparam int RC_PERR2 = 1;
   localparam int RC_PERR1 = 0;
   localparam int TC_DIAG = 7;
   localparam int TC_RDBLK = 6;
   localparam int TC_CLKDIS = 5;
   localparam int TC_TOG2 = 4;
   localparam int TC_TOG1 = 3;
   localparam int TC_NMI = 2;
   localparam int RS_IDLE2 = 6;
   localparam int RS_FULL1 = 5;
   localparam int RS_IDLE1 = 3;
   localparam int RS_FULL2 = 2;
   localparam int RS_DENS = 0;
   localparam int IS_P2 = 3;
   localparam int IS_P1 = 2;
   localparam int IS_RTC = 0;
   // Writable bits of the two control registers.
   localparam logic [7:0] RC_WMASK = 8'hf8;
   localparam logic [7:0] TC_WMASK = 8'hfc;
   // Bits after the start bit: eight data, parity, stop.
   localparam logic [3:0] FRAME_BITS = 4'ha;
   // ----------------------------------------------------------
   // Carrier from a port receiver to the register bank.
   // ----------------------------------------------------------
   typedef struct packed {
      logic busy;
      logic done;
      logic perr;
      logic [7:0] data;
   } kpsc_rx_t;
endpackage
`default_nettype wire

/* File: verilog/kpsc_port_rx.sv */
/*
 Receiver for one clocked serial peripheral port.
 Assumes line clock and data arrive raw from pins; both are
 synchronised here to mclk before use.
*/
`default_nettype none
module kpsc_port_rx (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic lineClk,
   input wire logic lineData,
   input wire logic abort,
   output kpsc_pkg::kpsc_rx_t rx
);
   import kpsc_pkg::*;

   typedef struct packed {
      logic clkS1;
      logic clkS2;
      logic datS1;
      logic datS2;
      logic clkPrev;
      logic busy;
      logic [3:0] cnt;
      logic [9:0] shift;
      logic done;
      logic perr;
      logic [7:0] data;
   } kpsc_rxst_t;

   kpsc_rxst_t s_r;
   kpsc_rxst_t s_nxt;

   // ----------------------------------------------------------
   // Frame capture on falling edges of the line clock.
   // ----------------------------------------------------------
   always_comb begin
      logic [9:0] sh;
      sh = {s_r.datS2, s_r.shift[9:1]};
      s_nxt = s_r;
      s_nxt.clkS1 = lineClk;
      s_nxt.clkS2 = s_r.clkS1;
      s_nxt.datS1 = lineData;
      s_nxt.datS2 = s_r.datS1;
      s_nxt.clkPrev = s_r.clkS2;
      s_nxt.done = 1'b0;
      if (abort) begin
         s_nxt.busy = 1'b0;
      end else if (s_r.clkPrev && !s_r.clkS2) begin
         if (!s_r.busy) begin
            s_nxt.busy = !s_r.datS2;
            s_nxt.cnt = '0;
         end else begin
            s_nxt.shift = sh;
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == FRAME_BITS - 4'h1) begin
               s_nxt.busy = 1'b0;
               s_nxt.done = 1'b1;
               s_nxt.data = sh[7:0];
               // Odd parity over data and parity bit.
               s_nxt.perr = ~(^sh[8:0]);
            end
         end
      end
   end

   // Register the whole state.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rx = '{busy: s_r.busy, done: s_r.done,
                 perr: s_r.perr, data: s_r.data};
endmodule
`default_nettype wire

/* File: verilog/kpsc_top.sv */
/*
 Register bank for two keyboard or pointer ports: clock line
 holding, sticky receive flags, shared interrupt merge.
 Assumes a classic Wishbone master on mclk, raw pins for the
 port lines and switches, and an RTC on mclk.
*/
// Operation
// - Shared disable bit holds both clocks low.
// - Clock-drive bit zero holds port clock low.
// - Writing receive-toggle one clears port flags.
// - Toggle held high: no clock hold after receive.
// - Keyboard-location bit is plain stored bit.
// - Parity error on receive sets sticky flag.
// - Parity flag clears by either toggle bit.
// - Key-lock bit follows keyswitch input.
// - Byte received sets receive-full bit.
// - Receive-full clears by either toggle bit.
// - Status bit zero mirrors floppy density pin.
// - Mask bit one blocks that interrupt source.
// - Masking never suppresses status bits.
// - Three sources merge onto one request.
// - Interrupt status shows pending sources.
// - Port pending clears by either toggle bit.
// - Clock pending clears on RTC status read.
// - Transmit-toggle bits exist per port.
// - Three diagnostic bits in transmit control.
// - Clock held low after a byte arrives.
// - Transmit write stores byte with parity.
`default_nettype none
module kpsc_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [kpsc_pkg::ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic firstPortClkIn,
   output logic firstPortClkOut,
   output logic firstPortClkOe,
   input wire logic firstPortDataIn,
   input wire logic secondPortClkIn,
   output logic secondPortClkOut,
   output logic secondPortClkOe,
   input wire logic secondPortDataIn,
   output logic [8:0] firstPortTxFrame,
   output logic [8:0] secondPortTxFrame,
   input wire logic keyUnlockedIn,
   input wire logic floppyDensityIn_n,
   input wire logic rtcIrq,
   input wire logic rtcStatusRead,
   output logic sharedInterruptRequest,
   output logic diagEnable,
   output logic diagReadBlock,
   output logic nmiDiagEnable
);
   import kpsc_pkg::*;

   // ----------------------------------------------------------
   // State of the bank.
   // ----------------------------------------------------------
   typedef struct packed {
      logic [7:0] rxCtl;
      logic [7:0] txCtl;
      logic perr1;
      logic perr2;
      logic full1;
      logic full2;
      logic pendRtc;
      logic hold1;
      logic hold2;
      logic maskP2;
      logic maskP1;
      logic maskRtc;
      logic lockS1;
      logic lockS2;
      logic densS1;
      logic densS2;
      logic [8:0] tx1;
      logic [8:0] tx2;
      logic ack;
      logic [31:0] rdat;
      logic irq;
      logic oe1;
      logic oe2;
   } kpsc_st_t;

   kpsc_st_t s_r;
   kpsc_st_t s_nxt;
   kpsc_rx_t rx1;
   kpsc_rx_t rx2;
   logic [9:0] idx;
   logic req;
   logic wr;
   logic clr1;
   logic clr2;

   // Odd parity bit for a transmit byte.
   function automatic logic oddPar(input logic [7:0] b);
      return ~(^b);
   endfunction

   // Write strobe to one register index.
   function automatic logic wrHit(input logic w,
                                  input logic [9:0] a,
                                  input logic [9:0] t);
      return w && (a == t);
   endfunction

   // ----------------------------------------------------------
   // Port receivers.
   // ----------------------------------------------------------
   // Each receiver is aborted while its clock is held low.
   kpsc_port_rx uRx1 (
      .mclk(mclk),
      .rst_n(rst_n),
      .lineClk(firstPortClkIn),
      .lineData(firstPortDataIn),
      .abort(s_r.oe1),
      .rx(rx1)
   );

   kpsc_port_rx uRx2 (
      .mclk(mclk),
      .rst_n(rst_n),
      .lineClk(secondPortClkIn),
      .lineData(secondPortDataIn),
      .abort(s_r.oe2),
      .rx(rx2)
   );

   // ----------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------
   // A request is taken once; ack follows on the next edge.
   assign idx = adr_i[ADDR_W-1:2];
   assign req = cyc_i && stb_i && !s_r.ack;
   assign wr = req && we_i && sel_i[0];
   // Clear strobes from either toggle bit written as one.
   assign clr1 = (wrHit(wr, idx, IDX_RXCTL) && dat_i[RC_TOG1])
      || (wrHit(wr, idx, IDX_TXCTL) && dat_i[TC_TOG1]);
   assign clr2 = (wrHit(wr, idx, IDX_RXCTL) && dat_i[RC_TOG2])
      || (wrHit(wr, idx, IDX_TXCTL) && dat_i[TC_TOG2]);

   // ----------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------
   always_comb begin
      logic [7:0] rd;
      logic [7:0] rc;
      logic [7:0] rs;
      logic [7:0] is;
      logic [7:0] im;
      rd = 8'h00;
      rc = s_r.rxCtl & RC_WMASK;
      rs = 8'h00;
      is = 8'h00;
      im = 8'h00;
      s_nxt = s_r;
      // Pin inputs pass two flip-flops.
      s_nxt.lockS1 = keyUnlockedIn;
      s_nxt.lockS2 = s_r.lockS1;
      s_nxt.densS1 = floppyDensityIn_n;
      s_nxt.densS2 = s_r.densS1;

      // Read views of every register.
      rc[RC_LOCK] = s_r.lockS2;
      rc[RC_PERR2] = s_r.perr2;
      rc[RC_PERR1] = s_r.perr1;
      rs[RS_IDLE2] = !rx2.busy;
      rs[RS_FULL1] = s_r.full1;
      rs[RS_IDLE1] = !rx1.busy;
      rs[RS_FULL2] = s_r.full2;
      rs[RS_DENS] = s_r.densS2;
      is[IS_P2] = s_r.full2;
      is[IS_P1] = s_r.full1;
      is[IS_RTC] = s_r.pendRtc;
      im[IS_P2] = s_r.maskP2;
      im[IS_P1] = s_r.maskP1;
      im[IS_RTC] = s_r.maskRtc;

      unique case (idx)
         IDX_RXCTL: rd = rc;
         IDX_TXDATA1: rd = rx1.data;
         IDX_TXDATA2: rd = rx2.data;
         IDX_TXCTL: rd = s_r.txCtl;
         IDX_RXSTAT: rd = rs;
         IDX_IRQSTAT: rd = is;
         IDX_IRQMASK: rd = im;
         default: rd = 8'h00;
      endcase

      // Bus answer: unmapped reads return zero.
      s_nxt.ack = req;
      if (req && !we_i) begin
         s_nxt.rdat = {24'h000000, rd};
      end

      // Register writes.
      if (wrHit(wr, idx, IDX_RXCTL)) begin
         s_nxt.rxCtl = dat_i[7:0] & RC_WMASK;
      end
      if (wrHit(wr, idx, IDX_TXCTL)) begin
         s_nxt.txCtl = dat_i[7:0] & TC_WMASK;
      end
      if (wrHit(wr, idx, IDX_IRQMASK)) begin
         s_nxt.maskP2 = dat_i[IS_P2];
         s_nxt.maskP1 = dat_i[IS_P1];
         s_nxt.maskRtc = dat_i[IS_RTC];
      end
      // Transmit byte stored with parity; no frame is started.
      if (wrHit(wr, idx, IDX_TXDATA1)) begin
         s_nxt.tx1 = {oddPar(dat_i[7:0]), dat_i[7:0]};
      end
      if (wrHit(wr, idx, IDX_TXDATA2)) begin
         s_nxt.tx2 = {oddPar(dat_i[7:0]), dat_i[7:0]};
      end

      // Sticky flags: a new event wins over a clear.
      s_nxt.full1 = rx1.done || (s_r.full1 && !clr1);
      s_nxt.full2 = rx2.done || (s_r.full2 && !clr2);
      s_nxt.perr1 = (rx1.done && rx1.perr)
         || (s_r.perr1 && !clr1);
      s_nxt.perr2 = (rx2.done && rx2.perr)
         || (s_r.perr2 && !clr2);
      s_nxt.pendRtc = rtcIrq
         || (s_r.pendRtc && !rtcStatusRead);

      // Hold the clock after a byte unless the toggle is high.
      s_nxt.hold1 = (rx1.done && !s_r.rxCtl[RC_TOG1])
         || (s_r.hold1 && !clr1);
      s_nxt.hold2 = (rx2.done && !s_r.rxCtl[RC_TOG2])
         || (s_r.hold2 && !clr2);

      // Clock line drive: enable high pulls the line low.
      s_nxt.oe1 = !s_nxt.rxCtl[RC_DRV1]
         || s_nxt.txCtl[TC_CLKDIS]
         || (s_nxt.hold1 && !s_nxt.rxCtl[RC_TOG1]);
      s_nxt.oe2 = !s_nxt.rxCtl[RC_DRV2]
         || s_nxt.txCtl[TC_CLKDIS]
         || (s_nxt.hold2 && !s_nxt.rxCtl[RC_TOG2]);

      // One shared request from unmasked pending sources.
      s_nxt.irq = (s_nxt.full2 && !s_nxt.maskP2)
         || (s_nxt.full1 && !s_nxt.maskP1)
         || (s_nxt.pendRtc && !s_nxt.maskRtc);
   end

   // ----------------------------------------------------------
   // State register.
   // ----------------------------------------------------------
   // Reset drives both clock lines low, as drive bits are zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.oe1 <= 1'b1;
         s_r.oe2 <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register; the clock-out pins are tied low.
   assign dat_o = s_r.rdat;
   assign ack_o = s_r.ack;
   assign firstPortClkOut = 1'b0;
   assign secondPortClkOut = 1'b0;
   assign firstPortClkOe = s_r.oe1;
   assign secondPortClkOe = s_r.oe2;
   assign firstPortTxFrame = s_r.tx1;
   assign secondPortTxFrame = s_r.tx2;
   assign sharedInterruptRequest = s_r.irq;
   assign diagEnable = s_r.txCtl[TC_DIAG];
   assign diagReadBlock = s_r.txCtl[TC_RDBLK];
   assign nmiDiagEnable = s_r.txCtl[TC_NMI];

   // ----------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Shared disable holds both lines.
   a_clk_disable_both: assert property (
      s_r.txCtl[TC_CLKDIS] |-> firstPortClkOe && secondPortClkOe)
      else $error("clock disable did not hold both lines");

   // Drive bit low holds the port line.
   a_drive_bit_low: assert property (
      !s_r.rxCtl[RC_DRV2] |-> secondPortClkOe)
      else $error("drive bit zero but line released");

   // Toggle write clears flags when no byte arrives.
   a_toggle_clears: assert property (
      (clr1 && !rx1.done) |=> !s_r.perr1 && !s_r.full1)
      else $error("receive toggle did not clear flags");

   // No hold after a byte while the toggle stays high.
   a_toggle_no_hold: assert property (
      (s_r.rxCtl[RC_TOG1] && rx1.done && !clr1
       && !wrHit(wr, idx, IDX_RXCTL)) |=> !s_r.hold1)
      else $error("clock held while toggle high");

   // Location bit keeps the written value.
   a_kbd_loc_store: assert property (
      wrHit(wr, idx, IDX_RXCTL)
      |=> s_r.rxCtl[RC_KBD1] == $past(dat_i[RC_KBD1]))
      else $error("keyboard location bit not stored");

   // A bad frame sets the parity flag.
   a_parity_set: assert property (
      rx2.done && rx2.perr |=> s_r.perr2)
      else $error("parity flag not set");

   // A byte sets the full bit even when masked.
   a_full_masked: assert property (
      rx1.done ##1 s_r.maskP1 |-> s_r.full1)
      else $error("full bit lost while masked");

   // Request matches unmasked pending sources.
   a_irq_merge: assert property (
      sharedInterruptRequest == ((s_r.full2 && !s_r.maskP2)
      || (s_r.full1 && !s_r.maskP1)
      || (s_r.pendRtc && !s_r.maskRtc)))
      else $error("shared request does not match sources");

   // Sources that are masked or idle keep the request low.
   a_mask_blocks: assert property (
      (s_r.maskRtc || !s_r.pendRtc) && (s_r.maskP1 || !s_r.full1)
      && (s_r.maskP2 || !s_r.full2) |-> !sharedInterruptRequest)
      else $error("masked source raised the request");

   // RTC pending clears on status read.
   a_rtc_clear: assert property (
      s_r.pendRtc && rtcStatusRead && !rtcIrq |=> !s_r.pendRtc)
      else $error("clock pending not cleared");

   // Line pulled low after a received byte.
   a_hold_after_rx: assert property (
      rx1.done && !s_r.rxCtl[RC_TOG1] && !clr1 |=> firstPortClkOe)
      else $error("clock not held after receive");

   // Bus answers one cycle after a request, for one cycle.
   a_bus_ack: assert property (
      req |=> ack_o ##1 !ack_o)
      else $error("bus answer not a single-cycle ack");

   c_rx_byte: cover property (rx1.done ##1 s_r.full1);
   c_irq_rise: cover property (!s_r.irq ##1 s_r.irq);
   c_clear: cover property (s_r.full2 ##1 clr2 ##1 !s_r.full2);
   c_rtc: cover property (s_r.pendRtc ##1 rtcStatusRead);
endmodule
`default_nettype wire
